//--- bench/processor_throttle_pwm_tb_top.sv
`timescale 1ns/10ps
module processor_throttle_pwm_tb_top;
  localparam int DIV = 4;
  localparam int PER = 80 * DIV;
  logic clock_in;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hot1_n = 1'b1;
  logic hot2_n = 1'b1;
  logic shorted = 1'b0;
  logic [7:0] rdata;
  logic rvalid, lvl1, lvl2, pout1, pout2, oe1, oe2;
  logic [23:0] win1, win2, n1, n2, nd;
  logic [15:0] len1, len2, per1, per2;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h7, 4'hE};
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  ptp_throttle #(.TICK_DIV(DIV)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .cpu1_regulator_hot_n_in(hot1_n), .cpu2_regulator_hot_n_in(hot2_n),
    .throttle_pins_shorted_in(shorted), .cpu1_throttle_pin_in(lvl1),
    .cpu1_throttle_pin_out(pout1), .cpu1_throttle_pin_oe_out(oe1),
    .cpu2_throttle_pin_in(lvl2), .cpu2_throttle_pin_out(pout2),
    .cpu2_throttle_pin_oe_out(oe2), .cpu1_monitor_window_out(win1),
    .cpu2_monitor_window_out(win2));
  ptp_cpu_model cpu1 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_oe_in(oe1), .pin_out_in(pout1), .pin_level_out(lvl1),
    .low_len_out(len1), .period_out(per1));
  ptp_cpu_model cpu2 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_oe_in(oe2), .pin_out_in(pout2), .pin_level_out(lvl2),
    .low_len_out(len2), .period_out(per2));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task check_value(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_value

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr_reg

  task check_reg(input logic [7:0] a, input logic [7:0] exp);
    int i;
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (rvalid !== 1'b1 && i < 4);
    compares++;
    if (rvalid !== 1'b1 || rdata !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, rdata, exp);
    end
  endtask : check_reg

  task sample_oe();
    n1 = 24'h0;
    n2 = 24'h0;
    nd = 24'h0;
    repeat (PER) begin
      @(posedge clock_in);
      n1 = n1 + 24'(oe1);
      n2 = n2 + 24'(oe2);
      nd = nd + 24'(oe1 ^ oe2);
    end
  endtask : sample_oe

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("timeout at %0t", $time);
      close_out();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    check_reg(8'hC6, 8'h00);
    check_reg(8'hC7, 8'h11);
    check_value(win1, 24'h004029 << 1);
    wr_reg(8'hC5, 8'hFF);
    check_reg(8'hC5, 8'h00);
    check_reg(8'hC6, 8'h00);
    $display("test reset done");
    wr_reg(8'hC7, 8'h93);
    check_reg(8'hC7, 8'h93);
    check_value(win1, 24'h004029 << 3);
    check_value(win2, 24'h004029 << 9);
    wr_reg(8'hC7, 8'hA0);
    check_reg(8'hC7, 8'hA0);
    check_value(win1, 24'h004029);
    check_value(win2, 24'h000000);
    $display("test interval done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'hC6, {4'h4, codes[k]});
      check_reg(8'hC6, {4'h4, codes[k]});
      repeat (3 * PER) @(posedge clock_in);
      check_value(24'(len1), 24'(20 * (codes[k] + 1)));
      check_value(24'(per1), 24'(PER));
      sample_oe();
      check_value(n2, 24'h0);
    end
    wr_reg(8'hC6, 8'h4F);
    repeat (4) @(posedge clock_in);
    sample_oe();
    check_value(n1, 24'(PER));
    $display("test duty done");
    shorted <= 1'b1;
    wr_reg(8'hC6, 8'h83);
    repeat (3 * PER) @(posedge clock_in);
    check_value(24'(len1), 24'h000050);
    check_value(24'(len2), 24'h000050);
    check_value(24'(per2), 24'(PER));
    sample_oe();
    check_value(nd, 24'h0);
    check_value(n1, 24'h000050);
    shorted <= 1'b0;
    repeat (2) @(posedge clock_in);
    sample_oe();
    check_value(n1, 24'h0);
    check_value(n2, 24'h000050);
    $display("test shorted done");
    wr_reg(8'hC6, 8'h00);
    hot1_n <= 1'b0;
    repeat (3) @(posedge clock_in);
    check_value(24'(oe1), 24'h1);
    check_value(24'(oe2), 24'h0);
    wr_reg(8'hC6, 8'h10);
    repeat (3) @(posedge clock_in);
    check_value(24'(oe1), 24'h0);
    hot1_n <= 1'b1;
    hot2_n <= 1'b0;
    repeat (3) @(posedge clock_in);
    check_value(24'(oe2), 24'h1);
    wr_reg(8'hC6, 8'h30);
    repeat (3) @(posedge clock_in);
    check_value(24'(oe2), 24'h0);
    hot2_n <= 1'b1;
    $display("test regulator done");
    close_out();
  end
endmodule : processor_throttle_pwm_tb_top

//--- bench/ptp_cpu_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Processor end of one throttle pin
// ****************************************************************
module ptp_cpu_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pin_oe_in,
  input wire logic pin_out_in,
  output logic pin_level_out,
  output logic [15:0] low_len_out,
  output logic [15:0] period_out
);
  logic level_q;
  logic [15:0] low_q;
  logic [15:0] since_q;
  // Pull-up holds the line high whenever the device lets go
  assign pin_level_out = pin_oe_in ? pin_out_in : 1'b1;
  // Measures the last low run and the fall-to-fall spacing in clocks
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= 1'b1;
      low_q <= 16'h0000;
      since_q <= 16'h0000;
      low_len_out <= 16'h0000;
      period_out <= 16'h0000;
    end else begin
      level_q <= pin_level_out;
      since_q <= since_q + 16'h0001;
      if (!pin_level_out) begin
        low_q <= low_q + 16'h0001;
      end
      if (pin_level_out && !level_q) begin
        low_len_out <= low_q;
        low_q <= 16'h0000;
      end
      if (!pin_level_out && level_q) begin
        period_out <= since_q;
        since_q <= 16'h0001;
      end
    end
  end
endmodule : ptp_cpu_model

//--- rtl/ptp_pkg.sv
package ptp_pkg;
  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned TICK_FREQ_HZ = 22_500;
  localparam int unsigned TICK_DIV = CLK_FREQ_HZ / TICK_FREQ_HZ;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] THROTTLE_CONTROL_ADDR = 8'hC6;
  localparam logic [7:0] THROTTLE_MONITOR_INTERVAL_ADDR = 8'hC7;
  localparam logic [7:0] THROTTLE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] THROTTLE_MONITOR_INTERVAL_RESET = 8'h11;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Throttle control fields
  localparam int unsigned DUTY_LSB = 0;
  localparam int unsigned DUTY_MSB = 3;
  localparam int unsigned CPU1_MASK_BIT = 4;
  localparam int unsigned CPU2_MASK_BIT = 5;
  localparam int unsigned CPU1_FORCE_BIT = 6;
  localparam int unsigned CPU2_FORCE_BIT = 7;

  // Monitor interval fields
  localparam int unsigned CPU1_INTERVAL_LSB = 0;
  localparam int unsigned CPU1_INTERVAL_MSB = 3;
  localparam int unsigned CPU2_INTERVAL_LSB = 4;
  localparam int unsigned CPU2_INTERVAL_MSB = 7;

  // ****************************************************************
  // Throttle waveform
  // ****************************************************************
  localparam logic [6:0] PERIOD_TICKS = 7'h50;
  localparam logic [6:0] DUTY_STEP_TICKS = 7'h05;
  localparam logic [6:0] COUNT_RESET = 7'h00;

  // ****************************************************************
  // Monitoring windows
  // ****************************************************************
  localparam int unsigned WINDOW_BASE_MS = 730;
  localparam logic [23:0] WINDOW_BASE_TICKS =
    24'((WINDOW_BASE_MS * TICK_FREQ_HZ) / 1000);
  localparam logic [3:0] INTERVAL_LAST_CODE = 4'h9;
  localparam logic [23:0] WINDOW_RESERVED = 24'h000000;
endpackage : ptp_pkg

//--- rtl/ptp_throttle.sv
`timescale 1ns/10ps
module ptp_throttle #(
  parameter int unsigned TICK_DIV = ptp_pkg::TICK_DIV
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic cpu1_regulator_hot_n_in,
  input wire logic cpu2_regulator_hot_n_in,
  input wire logic throttle_pins_shorted_in,
  input wire logic cpu1_throttle_pin_in,
  output logic cpu1_throttle_pin_out,
  output logic cpu1_throttle_pin_oe_out,
  input wire logic cpu2_throttle_pin_in,
  output logic cpu2_throttle_pin_out,
  output logic cpu2_throttle_pin_oe_out,
  output logic [23:0] cpu1_monitor_window_out,
  output logic [23:0] cpu2_monitor_window_out
);
  // ****************************************************************
  // Tick source
  // ****************************************************************
  logic tick;

  ptp_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] throttle_control_q;
  logic [7:0] throttle_control_d;
  logic [7:0] throttle_monitor_interval_q;
  logic [7:0] throttle_monitor_interval_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    throttle_control_d = throttle_control_q;
    throttle_monitor_interval_d = throttle_monitor_interval_q;
    rdata_d = rdata_q;
    rvalid_d = reg_read_in;
    if (reg_write_in && reg_addr_in == ptp_pkg::THROTTLE_CONTROL_ADDR) begin
      throttle_control_d = reg_wdata_in;
    end else if (reg_write_in &&
                 reg_addr_in == ptp_pkg::THROTTLE_MONITOR_INTERVAL_ADDR) begin
      throttle_monitor_interval_d = reg_wdata_in;
    end
    if (reg_read_in) begin
      if (reg_addr_in == ptp_pkg::THROTTLE_CONTROL_ADDR) begin
        rdata_d = throttle_control_q;
      end else if (reg_addr_in ==
                   ptp_pkg::THROTTLE_MONITOR_INTERVAL_ADDR) begin
        rdata_d = throttle_monitor_interval_q;
      end else begin
        rdata_d = ptp_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      throttle_control_q <= ptp_pkg::THROTTLE_CONTROL_RESET;
      throttle_monitor_interval_q <=
        ptp_pkg::THROTTLE_MONITOR_INTERVAL_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      throttle_control_q <= throttle_control_d;
      throttle_monitor_interval_q <= throttle_monitor_interval_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic [3:0] throttle_duty_select;
  logic [1:0] regulator_hot_mask;
  logic [1:0] force_throttle;
  logic [1:0] regulator_hot;
  logic [3:0] interval_code [2];
  logic [6:0] assert_width;

  assign throttle_duty_select =
    throttle_control_q[ptp_pkg::DUTY_MSB:ptp_pkg::DUTY_LSB];
  assign regulator_hot_mask = {throttle_control_q[ptp_pkg::CPU2_MASK_BIT],
                               throttle_control_q[ptp_pkg::CPU1_MASK_BIT]};
  assign force_throttle = {throttle_control_q[ptp_pkg::CPU2_FORCE_BIT],
                           throttle_control_q[ptp_pkg::CPU1_FORCE_BIT]};
  assign regulator_hot = {~cpu2_regulator_hot_n_in, ~cpu1_regulator_hot_n_in};
  assign interval_code[0] = throttle_monitor_interval_q[
    ptp_pkg::CPU1_INTERVAL_MSB:ptp_pkg::CPU1_INTERVAL_LSB];
  assign interval_code[1] = throttle_monitor_interval_q[
    ptp_pkg::CPU2_INTERVAL_MSB:ptp_pkg::CPU2_INTERVAL_LSB];
  // Width in ticks, 5 to 80
  assign assert_width = 7'(ptp_pkg::DUTY_STEP_TICKS *
                           ({3'h0, throttle_duty_select} + 7'h01));

  // ****************************************************************
  // Per-output waveform
  // ****************************************************************
  logic [6:0] count_q [2];
  logic [6:0] count_d [2];
  logic [1:0] drive_q;
  logic [1:0] drive_d;
  logic [23:0] window_q [2];
  logic [23:0] window_d [2];
  logic any_force;

  assign any_force = |force_throttle;

  for (genvar i = 0; i < 2; i++) begin : g_out
    logic forced;
    always_comb begin
      if (!tick) begin
        count_d[i] = count_q[i];
      end else if (count_q[i] == ptp_pkg::PERIOD_TICKS - 7'h01) begin
        count_d[i] = ptp_pkg::COUNT_RESET;
      end else begin
        count_d[i] = count_q[i] + 7'h01;
      end
      // Shorted pins share the force request
      forced = throttle_pins_shorted_in ? any_force :
               force_throttle[i];
      drive_d[i] = (forced && count_q[i] < assert_width) ||
                   (regulator_hot[i] && !regulator_hot_mask[i]);
      if (interval_code[i] > ptp_pkg::INTERVAL_LAST_CODE) begin
        window_d[i] = ptp_pkg::WINDOW_RESERVED;
      end else begin
        window_d[i] = ptp_pkg::WINDOW_BASE_TICKS << interval_code[i];
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        count_q[i] <= ptp_pkg::COUNT_RESET;
        drive_q[i] <= 1'b0;
        window_q[i] <= ptp_pkg::WINDOW_BASE_TICKS << 1;
      end else begin
        count_q[i] <= count_d[i];
        drive_q[i] <= drive_d[i];
        window_q[i] <= window_d[i];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic pin_low_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= 1'b0;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign cpu1_throttle_pin_out = pin_low_q;
  assign cpu2_throttle_pin_out = pin_low_q;
  assign cpu1_throttle_pin_oe_out = drive_q[0];
  assign cpu2_throttle_pin_oe_out = drive_q[1];
  assign cpu1_monitor_window_out = window_q[0];
  assign cpu2_monitor_window_out = window_q[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_count_wrap: assert property (
    tick && count_q[0] == 7'h4F |=> count_q[0] == 7'h00)
    else $error("throttle counter did not wrap after 80 ticks");

  a_count_hold: assert property (
    !tick |=> $stable(count_q[1]))
    else $error("throttle counter moved without a tick");

  a_full_duty: assert property (
    force_throttle[0] && throttle_duty_select == 4'hF |=> drive_q[0])
    else $error("full duty did not hold the output asserted");

  a_min_duty: assert property (
    force_throttle == 2'b01 && throttle_duty_select == 4'h0 &&
    count_q[0] >= 7'h05 && cpu1_regulator_hot_n_in |=> !drive_q[0])
    else $error("minimum duty asserted beyond 5 ticks");

  a_force_own: assert property (
    force_throttle == 2'b01 && !throttle_pins_shorted_in &&
    cpu2_regulator_hot_n_in |=> !drive_q[1])
    else $error("cpu1 force leaked onto cpu2 output");

  a_short_same: assert property (
    throttle_pins_shorted_in && any_force && count_q[0] == count_q[1] &&
    cpu1_regulator_hot_n_in && cpu2_regulator_hot_n_in
    |=> drive_q[0] == drive_q[1])
    else $error("shorted outputs differ");

  a_regulator_pass: assert property (
    !cpu2_regulator_hot_n_in && !regulator_hot_mask[1] |=> drive_q[1])
    else $error("unmasked regulator hot did not assert output");

  a_regulator_mask: assert property (
    !cpu1_regulator_hot_n_in && regulator_hot_mask[0] &&
    force_throttle == 2'b00 |=> !drive_q[0])
    else $error("masked regulator hot asserted output");

  a_ctrl_write: assert property (
    reg_write_in && reg_addr_in == 8'hC6 |=>
    throttle_control_q == $past(reg_wdata_in) &&
    throttle_duty_select == $past(reg_wdata_in[3:0]) &&
    regulator_hot_mask == $past(reg_wdata_in[5:4]) &&
    force_throttle == $past(reg_wdata_in[7:6]))
    else $error("control register write lost");

  a_window_code: assert property (
    interval_code[0] == 4'h0 ##1 interval_code[0] == 4'h0
    |-> cpu1_monitor_window_out == 24'h004029)
    else $error("interval code 0 window wrong");

  a_read_answer: assert property (
    reg_read_in && reg_addr_in == 8'hC7 |=>
    reg_rvalid_out && reg_rdata_out == $past(throttle_monitor_interval_q))
    else $error("interval register read wrong");

  c_force_both: cover property (force_throttle == 2'b11 ##1 drive_q == 2'b11);
  c_wrap: cover property (tick && count_q[0] == 7'h4F);
  c_shorted: cover property (throttle_pins_shorted_in &&
                             force_throttle == 2'b10 ##1 drive_q[0]);
  c_reg_hot: cover property (!cpu1_regulator_hot_n_in ##1 drive_q[0]);
endmodule : ptp_throttle

//--- rtl/ptp_tick_gen.sv
`timescale 1ns/10ps
module ptp_tick_gen #(
  parameter int unsigned DIV = ptp_pkg::TICK_DIV
) (
  input wire logic clock_in,
  input wire logic rst_in,
  output logic tick_out
);
  // ****************************************************************
  // Divider for the internal tick
  // ****************************************************************
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    if (div_q == 16'(DIV - 1)) begin
      div_d = 16'h0000;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 16'h0001;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule : ptp_tick_gen
